// File: hw/lprs_fifo.sv
// Synchronous FIFO with valid/ready on both sides and registered read data
`timescale 1ns/100ps
module lprs_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             core_clk,   // Clock
  input  wire logic             rst_n,      // Synchronised reset, active low
  input  wire logic [WIDTH-1:0] in_data,    // Write data
  input  wire logic             in_valid,   // Write request
  output      logic             in_ready,   // Not full
  output      logic [WIDTH-1:0] out_data,   // Read data, registered
  output      logic             out_valid,  // Not empty
  input  wire logic             out_ready   // Reader takes word
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             out_valid_r;
  wire              push;
  wire              pop;
  wire              load;

  // Head word sits in an output register so data come from flip-flops
  assign in_ready  = ((count_r + (AW+1)'(out_valid_r)) != (AW+1)'(DEPTH));  // Head register counts toward DEPTH
  assign push      = in_valid && in_ready;
  assign pop       = out_valid_r && out_ready;
  assign load      = (count_r != '0) && (!out_valid_r || pop);
  assign out_valid = out_valid_r;

  // Storage array carries no reset
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // Pointers, occupancy and the output register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r    <= '0;
      rd_ptr_r    <= '0;
      count_r     <= '0;
      out_valid_r <= 1'b0;
      out_data    <= '0;
    end else begin
      if (push) wr_ptr_r <= wr_ptr_r + AW'(1);
      if (load) begin
        out_data <= mem_r[rd_ptr_r];
        rd_ptr_r <= rd_ptr_r + AW'(1);
      end
      count_r     <= count_r + (AW+1)'(push) - (AW+1)'(load);
      out_valid_r <= load || (out_valid_r && !pop);
    end
  end
endmodule : lprs_fifo

// File: hw/lprs_pkg.sv
// Package: shared constants and carrier types for the linear pixel readout sequencer
package lprs_pkg;
  localparam int unsigned SECTION_PIXELS = 640;         // Pixels per section
  localparam int unsigned RESET_CYCLES   = 18;          // Integrator reset length after start
  localparam int unsigned PIXEL_BITS     = 12;          // Digitised pixel sample width
  localparam int unsigned FIFO_DEPTH     = 32;          // Output FIFO depth in words
  localparam int unsigned CNT_BITS       = 11;          // Wide enough for 0..2047
  localparam logic [CNT_BITS-1:0] CNT_IDLE = 11'h0_000;  // Counter value when idle

  // Per-section phase of the readout sequence
  typedef enum logic [2:0] {
    LPRS_IDLE  = 3'b001,
    LPRS_SHIFT = 3'b010,
    LPRS_CHAIN = 3'b100
  } lprs_phase_type;

  // One pixel sample leaving a section
  typedef struct packed {
    logic                  section;   // 0 = first section, 1 = second
    logic [9:0]            index;     // Pixel index within section
    logic [PIXEL_BITS-1:0] level;     // Sampled level
  } lprs_pixel_type;

  localparam int unsigned WORD_BITS = $bits(lprs_pixel_type);
endpackage : lprs_pkg

// File: hw/lprs_sequencer.sv
// Two-section linear pixel readout sequencer with output FIFO
`timescale 1ns/100ps
module lprs_sequencer
  import lprs_pkg::*;
#(
  parameter int unsigned PIXELS = SECTION_PIXELS,   // Pixels per section
  parameter int unsigned RESETS = RESET_CYCLES,     // Reset length in ticks
  parameter int unsigned DEPTH  = FIFO_DEPTH        // Output FIFO depth
) (
  input  wire logic                  core_clk,            // 25 MHz clock
  input  wire logic                  reset_n,             // Async reset, active low
  input  wire logic                  sec1_shift_tick,     // Section 1 shift enable pulse
  input  wire logic                  sec2_shift_tick,     // Section 2 shift enable pulse
  input  wire logic                  sec1_start_pulse_in, // Section 1 start
  input  wire logic                  sec2_start_pulse_in, // Section 2 start
  input  wire logic                  sec1_freeze_in,      // Section 1 hold
  input  wire logic                  sec2_freeze_in,      // Section 2 hold
  input  wire logic [2*PIXEL_BITS-1:0] pixel_level_in,    // Live integrator levels, sec1 low
  output      logic                  sec1_chain_out,      // Section 1 chain pulse
  output      logic                  sec2_chain_out,      // Section 2 chain pulse
  output      logic [PIXEL_BITS-1:0] sec1_pixel_voltage,  // Section 1 pixel output
  output      logic                  sec1_pixel_oe_n,     // Low while section 1 drives
  output      logic [PIXEL_BITS-1:0] sec2_pixel_voltage,  // Section 2 pixel output
  output      logic                  sec2_pixel_oe_n,     // Low while section 2 drives
  output      logic                  sec1_integrating,    // Section 1 integrating
  output      logic                  sec2_integrating,    // Section 2 integrating
  output      lprs_pixel_type        pix_data,            // FIFO head sample
  output      logic                  pix_valid,           // FIFO head valid
  input  wire logic                  pix_ready,           // Consumer takes sample
  output      logic                  pix_overflow         // Sticky: sample lost to a full FIFO or to a same-cycle tie
);
  logic rst_meta_r;
  logic rst_n_r;

  // Reset released through two flops
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // Next value of a shift position counter; zero means idle
  function automatic logic [CNT_BITS-1:0] pos_next(input logic [CNT_BITS-1:0] pos,
                                                   input logic start,
                                                   input logic [CNT_BITS-1:0] last);
    if (start)
      pos_next = 11'h0_001;
    else if (pos == CNT_IDLE || pos > last)
      pos_next = CNT_IDLE;
    else
      pos_next = pos + 11'h0_001;
  endfunction : pos_next

  localparam logic [CNT_BITS-1:0] LAST_POS  = CNT_BITS'(PIXELS);       // Chain rises here
  localparam logic [CNT_BITS-1:0] RESET_END = CNT_BITS'(RESETS);

  wire [1:0] tick    = {sec2_shift_tick, sec1_shift_tick};
  wire [1:0] start   = {sec2_start_pulse_in, sec1_start_pulse_in};
  wire [1:0] freeze  = {sec2_freeze_in, sec1_freeze_in};

  logic [CNT_BITS-1:0]   pos_r    [2];
  logic [CNT_BITS-1:0]   rst_cnt_r[2];
  logic [1:0]            freeze_d_r;
  logic [1:0]            integ_r;
  logic [PIXEL_BITS-1:0] pix_out_r[2];
  logic [1:0]            drive_r;
  logic [1:0]            chain_r;
  lprs_phase_type        phase    [2];
  logic [1:0]            fifo_in_valid;
  lprs_pixel_type        fifo_word[2];
  wire                   fifo_ready;
  logic                  ovf_r;

  genvar s;
  generate
    for (s = 0; s < 2; s++) begin : g_sec
      logic [PIXEL_BITS-1:0] hold_buf_r [SECTION_PIXELS];  // Parallel buffer
      wire  freeze_rise = freeze[s] && !freeze_d_r[s];     // Freeze from rising edge
      wire  captured    = tick[s] && start[s];             // Start taken at tick
      wire  [CNT_BITS-1:0] pos_nxt = pos_next(pos_r[s], captured, LAST_POS);
      wire  out_phase   = (pos_nxt != CNT_IDLE) && (pos_nxt <= LAST_POS);
      wire  [9:0] pix_idx = pos_nxt[9:0] - 10'h001;
      // A freeze in the start cycle has not reached the buffer yet, so the live level bypasses it;
      // valid because every pixel of the buffer loads the same live level
      wire  [PIXEL_BITS-1:0] cur_level = freeze_rise ? pixel_level_in[s*PIXEL_BITS +: PIXEL_BITS] :
                                                       hold_buf_r[pix_idx];

      assign phase[s] = (pos_r[s] == CNT_IDLE) ? LPRS_IDLE :
                        (pos_r[s] > LAST_POS)  ? LPRS_CHAIN : LPRS_SHIFT;

      // Freeze copies this section's live level into every buffer entry in the same cycle
      always_ff @(posedge core_clk) begin
        if (freeze_rise) begin
          for (int p = 0; p < SECTION_PIXELS; p++)
            hold_buf_r[p] <= pixel_level_in[s*PIXEL_BITS +: PIXEL_BITS];
        end
      end

      // Position, chain and output drive move only on this section's tick; a freeze edge also clears the reset window
      always_ff @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
          pos_r[s]     <= CNT_IDLE;
          rst_cnt_r[s] <= CNT_IDLE;
          freeze_d_r[s]<= 1'b0;
          integ_r[s]   <= 1'b1;
          pix_out_r[s] <= '0;
          drive_r[s]   <= 1'b0;
          chain_r[s]   <= 1'b0;
        end else begin
          freeze_d_r[s] <= freeze[s];
          if (freeze_rise) begin
            integ_r[s]   <= 1'b0;                            // Integrator reset begins
            rst_cnt_r[s] <= CNT_IDLE;
          end
          if (tick[s]) begin
            pos_r[s] <= pos_nxt;                             // 640-step sequence
            if (captured)
              rst_cnt_r[s] <= 11'h0_001;
            else if (rst_cnt_r[s] != CNT_IDLE && rst_cnt_r[s] < RESET_END)
              rst_cnt_r[s] <= rst_cnt_r[s] + 11'h0_001;
            if (!integ_r[s] && rst_cnt_r[s] == RESET_END && !captured && !freeze_rise)
              integ_r[s] <= 1'b1;                            // Reset ends 18 ticks after start
            chain_r[s] <= (pos_nxt == LAST_POS);             // Rise on 640th, fall on 641st
            drive_r[s] <= out_phase;                         // Released outside output phase
            if (out_phase)
              pix_out_r[s] <= cur_level;                      // Array order
          end
        end
      end

      // Each presented pixel is also offered to the FIFO for the digital consumer
      assign fifo_in_valid[s] = tick[s] && out_phase;
      assign fifo_word[s]     = '{section: 1'(s), index: pix_idx, level: cur_level};
    end
  endgenerate

  // Chain of section 2 ends data or starts a cascaded device
  assign sec1_chain_out     = chain_r[0];
  assign sec2_chain_out     = chain_r[1];
  assign sec1_pixel_voltage = pix_out_r[0];
  assign sec2_pixel_voltage = pix_out_r[1];
  assign sec1_pixel_oe_n    = !drive_r[0];
  assign sec2_pixel_oe_n    = !drive_r[1];
  assign sec1_integrating   = integ_r[0];
  assign sec2_integrating   = integ_r[1];

  // Section 1 wins the FIFO port if both present in one cycle; the loser is flagged
  wire            push_any  = |fifo_in_valid;
  lprs_pixel_type push_word;
  assign push_word = fifo_in_valid[0] ? fifo_word[0] : fifo_word[1];
  wire            lost      = (push_any && !fifo_ready) || (&fifo_in_valid);

  // Sticky loss flag, cleared only by reset since no software can reach it
  always_ff @(posedge core_clk or negedge rst_n_r) begin
    if (!rst_n_r) ovf_r <= 1'b0;
    else if (lost) ovf_r <= 1'b1;
  end
  assign pix_overflow = ovf_r;

  lprs_fifo #(.WIDTH(WORD_BITS), .DEPTH(DEPTH)) u_fifo (
    .core_clk  (core_clk),
    .rst_n     (rst_n_r),
    .in_data   (push_word),
    .in_valid  (push_any),
    .in_ready  (fifo_ready),
    .out_data  (pix_data),
    .out_valid (pix_valid),
    .out_ready (pix_ready)
  );

  // Section 1 chain rises when the position reaches PIXELS, on the PIXELS-th tick counting the start capture
  AST_CHAIN_RISE: assert property (@(posedge core_clk) disable iff (!rst_n_r)
    $rose(sec1_chain_out) |-> pos_r[0] == LAST_POS)
    else $error("chain 1 rose at wrong position");
  // Chain lasts one tick and falls on the next tick
  AST_CHAIN_FALL: assert property (@(posedge core_clk) disable iff (!rst_n_r)
    sec1_chain_out && sec1_shift_tick && !sec1_start_pulse_in |=> !sec1_chain_out && sec1_pixel_oe_n)
    else $error("chain 1 did not end on next tick");
  // Output released whenever the section is idle
  AST_HIZ_IDLE: assert property (@(posedge core_clk) disable iff (!rst_n_r)
    phase[0] == LPRS_IDLE |-> sec1_pixel_oe_n)
    else $error("section 1 drives while idle");
  // A captured start puts the section into output phase
  AST_START: assert property (@(posedge core_clk) disable iff (!rst_n_r)
    sec2_shift_tick && sec2_start_pulse_in |=> !sec2_pixel_oe_n && pos_r[1] == 11'h0_001)
    else $error("section 2 start not taken");
  // Freeze edge stops integration
  AST_FREEZE: assert property (@(posedge core_clk) disable iff (!rst_n_r)
    $rose(sec1_freeze_in) |=> !sec1_integrating)
    else $error("freeze did not stop integration");
  // Integration resumes only when the reset count is complete
  AST_RESET_END: assert property (@(posedge core_clk) disable iff (!rst_n_r)
    $rose(sec1_integrating) |-> $past(rst_cnt_r[0]) == RESET_END)
    else $error("integrator reset length wrong");
  // Position only moves on the section's own tick
  AST_OWN_TICK: assert property (@(posedge core_clk) disable iff (!rst_n_r)
    !sec2_shift_tick |=> $stable(pos_r[1]))
    else $error("section 2 moved without tick");
  // Pixel index follows position in order
  AST_ORDER: assert property (@(posedge core_clk) disable iff (!rst_n_r)
    fifo_in_valid[0] |-> fifo_word[0].index == 10'(pos_r[0]))
    else $error("pixel out of order");
  // Position never runs beyond the chain step
  AST_BOUND: assert property (@(posedge core_clk) disable iff (!rst_n_r)
    pos_r[0] <= LAST_POS + 11'h0_001)
    else $error("position out of range");
endmodule : lprs_sequencer

// File: tb/linear_pixel_readout_sequencer_tb_top.sv
// Testbench: sequencer with controller model and a stalling sample consumer
`timescale 1ns/100ps
module linear_pixel_readout_sequencer_tb_top;
  import lprs_pkg::*;
  logic                    core_clk  = 1'b0;
  logic                    reset_n   = 1'b0;
  logic                    go        = 1'b0;
  logic                    serial    = 1'b0;
  logic [3:0]              gap       = 4'h1;
  logic [2*PIXEL_BITS-1:0] lvl       = 24'h00_0000;
  logic                    pix_ready = 1'b0;
  logic                    t1, t2, s1, s2, f1, f2, c1, c2, oe1, oe2, i1, i2, pv, ovf, busy;
  logic [PIXEL_BITS-1:0]   v1, v2;
  lprs_pixel_type          pd;
  int                      n_errors = 0;
  int                      n_tests  = 0;

  // 25 MHz clock
  always #20 core_clk = ~core_clk;

  lprs_ctrl_model ctrl_u (.core_clk(core_clk), .go(go), .serial(serial), .gap(gap), .sec1_chain_out(c1),
    .sec1_shift_tick(t1), .sec2_shift_tick(t2), .sec1_start_pulse_in(s1), .sec2_start_pulse_in(s2),
    .sec1_freeze_in(f1), .sec2_freeze_in(f2), .busy(busy));

  lprs_sequencer dut_u (.core_clk(core_clk), .reset_n(reset_n), .sec1_shift_tick(t1), .sec2_shift_tick(t2),
    .sec1_start_pulse_in(s1), .sec2_start_pulse_in(s2), .sec1_freeze_in(f1), .sec2_freeze_in(f2),
    .pixel_level_in(lvl), .sec1_chain_out(c1), .sec2_chain_out(c2), .sec1_pixel_voltage(v1),
    .sec1_pixel_oe_n(oe1), .sec2_pixel_voltage(v2), .sec2_pixel_oe_n(oe2), .sec1_integrating(i1),
    .sec2_integrating(i2), .pix_data(pd), .pix_valid(pv), .pix_ready(pix_ready), .pix_overflow(ovf));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t ns: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // Reset for 6 cycles, then let the two-stage release settle
  task automatic t_reset();
    reset_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    check({c1, c2, pv, ovf}, 4'h0, "idle chain/valid/overflow");
    check({oe1, oe2, i1, i2}, 4'hf, "idle drive/integrate");
    $display("test reset done");
  endtask : t_reset

  task automatic start_frame(input logic ser, input logic [3:0] g);
    @(posedge core_clk);
    serial <= ser;
    gap    <= g;
    go     <= 1'b1;
    @(posedge core_clk);
    go     <= 1'b0;
  endtask : start_frame

  // Serial frame, prompt consumer: pixels in order, chain pulses at ticks 640 and 1280
  task automatic t_serial();
    int             k;
    int             w;
    int             n;
    lprs_pixel_type ew;
    k = 0;
    w = 0;
    lvl       <= {12'h5a5, 12'h3c1};
    pix_ready <= 1'b1;
    start_frame(1'b1, 4'h2);
    for (n = 0; n < 4000 && (k < 1281 || pv); n++) begin
      @(posedge core_clk);
      if (pv && pix_ready) begin
        ew = {w >= 640, 10'(w % 640), (w >= 640) ? 12'h5a5 : 12'h3c1};
        check(pd, ew, "serial word");
        w++;
      end
      if (t1) begin
        k++;
        // Live levels move after the freeze; the buffer must not follow
        if (k == 2) lvl <= 24'h00_0fff;
        #1;
        check(oe1, k > 640, "sec1 drive");
        check(c1, k == 640, "sec1 chain");
        check(i1, k >= 19, "sec1 integrating");
        check(oe2, !(k > 640 && k < 1281), "sec2 drive");
        check(c2, k == 1280, "sec2 chain");
        if (k <= 640) check(v1, 12'h3c1, "sec1 level");
        if (k > 640 && k < 1281) check(v2, 12'h5a5, "sec2 level");
      end
    end
    check(w, 1280, "serial word count");
    check(ovf, 1'b0, "serial overflow");
    $display("test serial done");
  endtask : t_serial

  // Parallel frame against a stalled consumer: FIFO fills, section 1 wins ties
  task automatic t_fill();
    int k;
    int j;
    int n;
    k = 0;
    j = 0;
    lvl       <= {12'h0c3, 12'h81e};
    pix_ready <= 1'b0;
    start_frame(1'b0, 4'h3);
    for (n = 0; n < 3000 && k < 641; n++) begin
      @(posedge core_clk);
      if (t2) begin
        k++;
        #1;
        check({c1, c2}, {k == 640, k == 640}, "parallel chains");
        check(oe2, k > 640, "sec2 drive");
        check(i2, k >= 19, "sec2 integrating");
        if (k <= 640) check(v2, 12'h0c3, "sec2 level");
      end
    end
    check({pv, ovf}, 2'b11, "full and overflow");
    @(posedge core_clk);
    pix_ready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge core_clk);
      if (pv && pix_ready) begin
        check(pd, {1'b0, 10'(j), 12'h81e}, "drained word");
        j++;
      end
    end
    check(j, 32, "fifo depth");
    $display("test fill done");
  endtask : t_fill

  initial begin
    t_reset();
    t_serial();
    t_fill();
    t_reset();
    tally_and_finish();
  end

  // Watchdog: the tests need under 8000 cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    tally_and_finish();
  end
endmodule : linear_pixel_readout_sequencer_tb_top

// File: tb/lprs_ctrl_model.sv
// Controller model: shift ticks, start and freeze pulses for both sections
`timescale 1ns/100ps
module lprs_ctrl_model (
  input  wire logic       core_clk,            // Clock
  input  wire logic       go,                  // Begin one frame
  input  wire logic       serial,              // 1 = sections linked
  input  wire logic [3:0] gap,                 // Cycles per tick, 1 = prompt
  input  wire logic       sec1_chain_out,      // From section 1
  output      logic       sec1_shift_tick,     // Section 1 tick
  output      logic       sec2_shift_tick,     // Section 2 tick
  output      logic       sec1_start_pulse_in, // Section 1 start
  output      logic       sec2_start_pulse_in, // Section 2 start
  output      logic       sec1_freeze_in,      // Section 1 hold
  output      logic       sec2_freeze_in,      // Section 2 hold
  output      logic       busy                 // Frame running
);
  logic [10:0] left_r  = 11'h000;
  logic [3:0]  wait_r  = 4'h0;
  logic        first_r = 1'b0;
  logic        tick_r  = 1'b0;
  logic        start_r = 1'b0;

  // One frame per go keeps integration spans long against frame length
  always_ff @(posedge core_clk) begin
    tick_r  <= 1'b0;
    start_r <= 1'b0;
    if (go) begin
      left_r  <= serial ? 11'h501 : 11'h281;  // Extra tick closes the last chain pulse
      wait_r  <= 4'h0;
      first_r <= 1'b1;
    end else if (left_r != 11'h000) begin
      if (wait_r == 4'h0) begin
        tick_r  <= 1'b1;
        start_r <= first_r;                   // Start seen by one tick only
        first_r <= 1'b0;
        left_r  <= left_r - 11'h001;
        wait_r  <= gap - 4'h1;
      end else begin
        wait_r <= wait_r - 4'h1;
      end
    end
  end

  // Strapping: freezes follow the first start, second start per mode
  assign sec1_shift_tick     = tick_r;
  assign sec2_shift_tick     = tick_r;
  assign sec1_start_pulse_in = start_r;
  assign sec1_freeze_in      = start_r;
  assign sec2_freeze_in      = start_r;
  assign sec2_start_pulse_in = serial ? sec1_chain_out : start_r;
  assign busy                = (left_r != 11'h000);
endmodule : lprs_ctrl_model
